// ==== hw/ccs_top.sv ====
// Purpose: CPU clock source selection with AHB-Lite register access.
// Assumes: clk is the 20 MHz bus clock; ticks arrive as one-cycle pulses.
// Notes: Clock paths are modelled as enables built from oscillator ticks.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module ccs_top
(
	input wire logic clk, // 20 MHz system clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic hsel, // AHB slave select.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic hwrite, // AHB write flag.
	input wire logic [2:0] hsize, // AHB transfer size.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB bus ready.
	output logic [31:0] hrdata, // AHB read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Slave response, always OKAY.
	input wire logic main_tick, // Main oscillator tick pulse.
	input wire logic sub_tick, // Raw subsystem tick pulse.
	input wire logic mult_tick, // Multiplied subsystem tick pulse.
	input wire logic wake, // Standby release request pulse.
	output logic cpu_clk_en, // CPU clock enable pulse.
	output logic main_osc_en, // Main oscillator run enable.
	output logic sub_osc_en, // Subsystem oscillator run enable.
	output logic feedback_resistor_off, // Feedback resistor disconnect.
	output logic mult_en, // Multiplier run enable.
	output logic periph_clk_en, // Main-derived peripheral clock enable.
	output logic sub_periph_clk_en, // Sub-clocked peripherals enable.
	output logic adc_sub_clk_en, // Converter sub clock enable.
	output logic halt_active, // HALT standby in force.
	output logic stop_active // STOP standby in force.
);
	// ---------------------------------------------------------------
	// Bus address phase capture
	// ---------------------------------------------------------------
	logic wr_pend_reg, wr_pend_next;
	logic [15:0] addr_reg, addr_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] mult_reg, mult_next;
	logic mult_locked_reg, mult_locked_next;
	logic [7:0] osc_reg, osc_next;
	logic [7:0] pcc_reg, pcc_next;
	logic [7:0] stby_reg, stby_next;
	logic src_sub_reg, src_sub_next;
	logic div4_reg, div4_next;
	logic mult_use_reg, mult_use_next;
	logic [8:0] sw_cnt_reg, sw_cnt_next;
	logic [1:0] div_cnt_reg, div_cnt_next;
	logic sub_half_reg, sub_half_next;
	logic mult_wait_reg, mult_wait_next;
	logic [31:0] rdata_next;
	logic [7:0] wbyte;
	logic addr_ok;
	logic want_sub;
	logic switching;

	// Register index match; every register owns one whole word, so two
	// registers with neighbouring indices never alias each other.
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] r);
		hit = (a == r);
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Register data always sits in the low byte of the word.
	assign wbyte = hwdata[7:0];
	assign addr_ok = hit(addr_reg, ccs_pkg::ADDR_SUB_CTRL) ||
		hit(addr_reg, ccs_pkg::ADDR_SUB_MULT_SEL) ||
		hit(addr_reg, ccs_pkg::ADDR_SUB_OSC_MODE) ||
		hit(addr_reg, ccs_pkg::ADDR_PROC_CLK) ||
		hit(addr_reg, ccs_pkg::ADDR_STANDBY);

	// ---------------------------------------------------------------
	// Register writes and standby control
	// ---------------------------------------------------------------
	// Writes land one cycle after the address phase, single wait-free.
	always_comb
	begin
		wr_pend_next = hsel && hready && htrans[1] && hwrite;
		addr_next = (hsel && hready && htrans[1]) ?
			haddr[17:2] : addr_reg;
		ctrl_next = ctrl_reg;
		mult_next = mult_reg;
		mult_locked_next = mult_locked_reg;
		osc_next = osc_reg;
		pcc_next = pcc_reg;
		stby_next = stby_reg;
		if (wr_pend_reg && addr_ok)
		begin
			// byte writes
			// A bit set from software arrives as a whole byte write.
			if (hit(addr_reg, ccs_pkg::ADDR_SUB_CTRL))
				ctrl_next = wbyte & ccs_pkg::MASK_SUB_CTRL;
			if (hit(addr_reg, ccs_pkg::ADDR_SUB_MULT_SEL) &&
				!mult_locked_reg)
			begin
				mult_next = wbyte & ccs_pkg::MASK_SUB_MULT;
				mult_locked_next = 1'b1;
			end
			if (hit(addr_reg, ccs_pkg::ADDR_SUB_OSC_MODE))
				osc_next = wbyte & ccs_pkg::MASK_SUB_OSC;
			if (hit(addr_reg, ccs_pkg::ADDR_PROC_CLK))
			begin
				pcc_next = wbyte & ccs_pkg::MASK_PROC_CLK;
				if (!src_sub_reg)
					pcc_next[ccs_pkg::BIT_MAIN_STOP] = 1'b0;
			end
			if (hit(addr_reg, ccs_pkg::ADDR_STANDBY))
			begin
				stby_next = wbyte & ccs_pkg::MASK_STANDBY;
				if (src_sub_reg)
					stby_next[ccs_pkg::BIT_STOP] = 1'b0;
			end
		end
		// Wake wins over a standby write in the same cycle.
		if (wake)
			stby_next = ccs_pkg::RST_STANDBY;
	end

	// ---------------------------------------------------------------
	// Clock source switching
	// ---------------------------------------------------------------
	// source select
	assign want_sub = ctrl_reg[ccs_pkg::BIT_SRC_SEL];
	assign switching = (want_sub != src_sub_reg) ||
		(!want_sub && pcc_reg[ccs_pkg::BIT_DIV_SEL] != div4_reg);

	// The old source keeps driving while a count of its own ticks runs
	// out, so the CPU never sees a short pulse across the change.
	always_comb
	begin
		logic old_tick;
		old_tick = 1'b0;
		src_sub_next = src_sub_reg;
		div4_next = div4_reg;
		sw_cnt_next = sw_cnt_reg;
		mult_use_next = mult_reg[ccs_pkg::BIT_MULT_EN];
		old_tick = src_sub_reg ? sub_tick : main_tick;
		if (!switching)
			sw_cnt_next = 9'h000;
		else if (old_tick)
		begin
			sw_cnt_next = sw_cnt_reg + 9'h001;
			if ((!src_sub_reg && want_sub &&
				sw_cnt_reg >= 9'(ccs_pkg::SWITCH_MAX_CLOCKS - 1)) ||
				(!src_sub_reg && !want_sub &&
				sw_cnt_reg >= 9'(ccs_pkg::MAIN_SWITCH_CLOCKS - 1)) ||
				(src_sub_reg &&
				sw_cnt_reg >= 9'(ccs_pkg::MIN_SWITCH_CLOCKS - 1)))
			begin
				src_sub_next = want_sub;
				div4_next = pcc_reg[ccs_pkg::BIT_DIV_SEL];
				sw_cnt_next = 9'h000;
			end
		end
	end

	// ---------------------------------------------------------------
	// CPU clock enable generation
	// ---------------------------------------------------------------
	// divide choice
	always_comb
	begin
		div_cnt_next = div_cnt_reg;
		sub_half_next = sub_half_reg;
		mult_wait_next = mult_wait_reg;
		cpu_clk_en = 1'b0;
		if (main_tick && main_osc_en)
			div_cnt_next = div_cnt_reg + 2'b01;
		if (halt_active && mult_use_reg)
			mult_wait_next = 1'b1;
		else if (mult_wait_reg && sub_tick)
			mult_wait_next = 1'b0;
		if (!halt_active && !stop_active)
		begin
			if (!src_sub_reg)
				cpu_clk_en = main_tick && main_osc_en &&
					(!div4_reg || div_cnt_reg == 2'b11);
			else if (mult_use_reg)
				cpu_clk_en = mult_tick && !mult_wait_reg;
			else
			begin
				if (sub_tick && sub_osc_en)
					sub_half_next = !sub_half_reg;
				cpu_clk_en = sub_tick && sub_osc_en && sub_half_reg;
			end
		end
	end

	// ---------------------------------------------------------------
	// Oscillator and peripheral gating
	// ---------------------------------------------------------------
	assign halt_active = stby_reg[ccs_pkg::BIT_HALT];
	assign stop_active = stby_reg[ccs_pkg::BIT_STOP];
	assign main_osc_en = reset_n && !stop_active &&
		!pcc_reg[ccs_pkg::BIT_MAIN_STOP];
	assign sub_osc_en = !osc_reg[ccs_pkg::BIT_SUB_STOP];
	assign feedback_resistor_off = osc_reg[ccs_pkg::BIT_FB_OFF];
	// multiplier select
	// The output stays off through the wake wait, so neither the CPU nor
	// the converter sees the multiplier while it settles.
	assign mult_en = mult_use_reg && sub_osc_en && !halt_active &&
		!stop_active && !mult_wait_reg;
	assign periph_clk_en = main_tick && main_osc_en;
	assign sub_periph_clk_en = sub_tick && sub_osc_en;
	assign adc_sub_clk_en = mult_tick && mult_en;

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// status bit
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			if (hit(haddr[17:2], ccs_pkg::ADDR_SUB_CTRL))
			begin
				rdata_next[7:0] = ctrl_reg;
				rdata_next[ccs_pkg::BIT_SRC_STATUS] = src_sub_reg;
			end
			else if (hit(haddr[17:2], ccs_pkg::ADDR_SUB_MULT_SEL))
				rdata_next[7:0] = mult_reg;
			else if (hit(haddr[17:2], ccs_pkg::ADDR_SUB_OSC_MODE))
				rdata_next[7:0] = osc_reg;
			else if (hit(haddr[17:2], ccs_pkg::ADDR_PROC_CLK))
				rdata_next[7:0] = pcc_reg;
			else if (hit(haddr[17:2], ccs_pkg::ADDR_STANDBY))
				rdata_next[7:0] = stby_reg;
		end
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	// control reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 16'h0000;
			ctrl_reg <= ccs_pkg::RST_SUB_CTRL;
			mult_reg <= ccs_pkg::RST_SUB_MULT;
			mult_locked_reg <= 1'b0;
			osc_reg <= ccs_pkg::RST_SUB_OSC;
			pcc_reg <= ccs_pkg::RST_PROC_CLK;
			stby_reg <= ccs_pkg::RST_STANDBY;
			src_sub_reg <= 1'b0;
			div4_reg <= 1'b1;
			mult_use_reg <= 1'b0;
			sw_cnt_reg <= 9'h000;
			div_cnt_reg <= 2'b00;
			sub_half_reg <= 1'b0;
			mult_wait_reg <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			addr_reg <= addr_next;
			ctrl_reg <= ctrl_next;
			mult_reg <= mult_next;
			mult_locked_reg <= mult_locked_next;
			osc_reg <= osc_next;
			pcc_reg <= pcc_next;
			stby_reg <= stby_next;
			src_sub_reg <= src_sub_next;
			div4_reg <= div4_next;
			mult_use_reg <= mult_use_next;
			sw_cnt_reg <= sw_cnt_next;
			div_cnt_reg <= div_cnt_next;
			sub_half_reg <= sub_half_next;
			mult_wait_reg <= mult_wait_next;
			hrdata <= rdata_next;
		end
	end
endmodule // ccs_top

// ==== common/ccs_pkg.sv ====
// Purpose: Shared constants and types for the CPU clock source selector.
// Assumes: Registers are reached over AHB-Lite with 32-bit words.
// Notes: Register data is 8 bits wide and sits in the low byte of a word.
package ccs_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	// Register indices; the bus byte address is four times the index.
	localparam logic [15:0] ADDR_SUB_MULT_SEL = 16'hff46;
	localparam logic [15:0] ADDR_SUB_OSC_MODE = 16'hfff0;
	localparam logic [15:0] ADDR_SUB_CTRL = 16'hfff2;
	localparam logic [15:0] ADDR_PROC_CLK = 16'hfffb;
	localparam logic [15:0] ADDR_STANDBY = 16'hff00;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_SRC_SEL = 4;
	localparam int BIT_SRC_STATUS = 5;
	localparam int BIT_MULT_EN = 0;
	localparam int BIT_SUB_STOP = 0;
	localparam int BIT_FB_OFF = 1;
	localparam int BIT_DIV_SEL = 1;
	localparam int BIT_MAIN_STOP = 7;
	localparam int BIT_HALT = 0;
	localparam int BIT_STOP = 1;
	// ---------------------------------------------------------------
	// Reset values and write masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_SUB_CTRL = 8'h00;
	localparam logic [7:0] RST_SUB_MULT = 8'h00;
	localparam logic [7:0] RST_SUB_OSC = 8'h00;
	localparam logic [7:0] RST_PROC_CLK = 8'h02;
	localparam logic [7:0] RST_STANDBY = 8'h00;
	localparam logic [7:0] MASK_SUB_CTRL = 8'h10;
	localparam logic [7:0] MASK_SUB_MULT = 8'h01;
	localparam logic [7:0] MASK_SUB_OSC = 8'h03;
	localparam logic [7:0] MASK_PROC_CLK = 8'h82;
	localparam logic [7:0] MASK_STANDBY = 8'h03;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int SWITCH_MAX_CLOCKS = 306;
	localparam int MAIN_SWITCH_CLOCKS = 4;
	localparam int MIN_SWITCH_CLOCKS = 2;
	// CPU clock choices.
	typedef enum logic [1:0] {
		CCS_SRC_MAIN_FAST,
		CCS_SRC_MAIN_DIV4,
		CCS_SRC_SUB_RAW,
		CCS_SRC_SUB_MULT
	} ccs_src_e;
	// Oscillator and clock gating controls.
	typedef struct packed {
		logic main_osc_run;
		logic sub_osc_run;
		logic feedback_resistor_off;
		logic mult_run;
		logic periph_clk_en;
		logic sub_periph_clk_en;
		logic adc_sub_clk_en;
	} ccs_gate_s;
endpackage

// ==== bench/ccs_chk_sva.sv ====
// Purpose: Port-level checks for the CPU clock source selector.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Bound to the top module from the testbench top file.
`timescale 1ns/1ns
module ccs_chk
(
	input wire logic clk, // System clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write flag.
	input wire logic [31:0] hrdata, // Read data.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Slave response.
	input wire logic main_tick, // Main tick.
	input wire logic sub_tick, // Raw sub tick.
	input wire logic mult_tick, // Multiplied tick.
	input wire logic main_osc_en, // Main oscillator run.
	input wire logic sub_osc_en, // Sub oscillator run.
	input wire logic mult_en, // Multiplier run.
	input wire logic periph_clk_en, // Peripheral clock.
	input wire logic sub_periph_clk_en, // Sub peripheral clock.
	input wire logic adc_sub_clk_en, // Converter clock.
	input wire logic halt_active, // HALT in force.
	input wire logic stop_active // STOP in force.
);
	// ------------------------------------------------------------
	// Clocking and sequences
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// HALT released: the multiplier must still be waiting.
	sequence s_wake;
		halt_active ##1 !halt_active;
	endsequence
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_ready;
		hreadyout && !hresp;
	endproperty
	property p_rd_idle;
		!(hsel && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000;
	endproperty
	property p_periph;
		periph_clk_en == (main_tick && main_osc_en);
	endproperty
	property p_sub_periph;
		sub_periph_clk_en == (sub_tick && sub_osc_en);
	endproperty
	property p_adc;
		adc_sub_clk_en == (mult_tick && mult_en);
	endproperty
	property p_halt_mult;
		halt_active |-> !mult_en;
	endproperty
	property p_wake;
		s_wake |-> !mult_en;
	endproperty
	property p_stop_main;
		stop_active |-> !main_osc_en;
	endproperty
	property p_mult_osc;
		mult_en |-> sub_osc_en;
	endproperty
	a_ready: assert property (p_ready)
		else $error("slave not ready or not OKAY");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside a data phase");
	a_periph: assert property (p_periph)
		else $error("peripheral clock not tied to main clock");
	a_sub_periph: assert property (p_sub_periph)
		else $error("sub peripheral clock wrong");
	a_adc: assert property (p_adc)
		else $error("converter clock not gated by multiplier");
	a_halt_mult: assert property (p_halt_mult)
		else $error("multiplier runs during HALT");
	a_wake: assert property (p_wake)
		else $error("multiplier skipped its wake wait");
	a_stop_main: assert property (p_stop_main)
		else $error("main oscillator runs during STOP");
	a_mult_osc: assert property (p_mult_osc)
		else $error("multiplier runs with sub oscillator off");
endmodule // ccs_chk

// ==== bench/test_cpu_clock_source_select.sv ====
// Purpose: Self-checking bench for the CPU clock source selector.
// Assumes: Byte address of a register is four times its index.
// Notes: Ticks come from a free counter; standby register is chosen.
`timescale 1ns/1ns
module test_cpu_clock_source_select;
	localparam logic [15:0] A_CT = ccs_pkg::ADDR_SUB_CTRL;
	localparam logic [15:0] A_MS = ccs_pkg::ADDR_SUB_MULT_SEL;
	localparam logic [15:0] A_OM = ccs_pkg::ADDR_SUB_OSC_MODE;
	localparam logic [15:0] A_PC = ccs_pkg::ADDR_PROC_CLK;
	localparam logic [15:0] A_SB = ccs_pkg::ADDR_STANDBY;
	logic clk, reset_n, hsel, hwrite, hready, wake;
	logic main_tick, sub_tick, mult_tick, hreadyout, hresp, cpu_clk_en;
	logic main_osc_en, sub_osc_en, feedback_resistor_off, mult_en;
	logic periph_clk_en, sub_periph_clk_en, adc_sub_clk_en;
	logic halt_active, stop_active;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] rd;
	logic [7:0] tick_cnt = 8'h00;
	int n_fail = 0;
	int samples_checked = 0;
	assign hready = hreadyout;
	ccs_top i_dut
	(
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .main_tick(main_tick), .sub_tick(sub_tick),
		.mult_tick(mult_tick), .wake(wake), .cpu_clk_en(cpu_clk_en),
		.main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
		.feedback_resistor_off(feedback_resistor_off), .mult_en(mult_en),
		.periph_clk_en(periph_clk_en), .sub_periph_clk_en(sub_periph_clk_en),
		.adc_sub_clk_en(adc_sub_clk_en), .halt_active(halt_active),
		.stop_active(stop_active)
	);
	// Clock of 50 ns period.
	always #25 clk = ~clk;
	// Oscillator ticks: main every 2, multiplied every 4, raw sub every 16.
	always @(posedge clk)
	begin
		tick_cnt <= tick_cnt + 8'h01;
		main_tick <= tick_cnt[0];
		mult_tick <= (tick_cnt[1:0] == 2'h3);
		sub_tick <= (tick_cnt[3:0] == 4'hf);
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// One single word transfer; the master never assumes a latency.
	task automatic bus(input logic wr, input logic [15:0] idx,
		input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {14'h0000, idx, 2'h0};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdchk(input string what, input logic [15:0] idx,
		input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(what, exp, rd);
	endtask
	// Counts CPU clock pulses over 64 cycles against the expected rate.
	task automatic rate(input string what, input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		repeat (64)
		begin
			@(negedge clk);
			n = n + 8'(cpu_clk_en);
		end
		chk(what, exp, n);
	endtask
	// Release of a standby mode, timed just after a raw sub tick.
	task automatic wake_up;
		do @(posedge clk); while (sub_tick !== 1'b1);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rst;
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		chk("osc in reset", 8'h00, 8'(main_osc_en));
		reset_n <= 1'b1;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog: the tests need about 3500 cycles.
	initial
	begin
		#(20000 * 50);
		n_fail++;
		$display("BAD watchdog expected done seen hang");
		close_out();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		{hsel, hwrite, wake} = 3'h0;
		{haddr, hwdata} = 64'h0000_0000_0000_0000;
		htrans = 2'h0;
		hsize = 3'h2;
		rst();
		rdchk("ctrl", A_CT, 8'h00);
		rdchk("mult", A_MS, 8'h00);
		rdchk("osc", A_OM, 8'h00);
		rdchk("proc", A_PC, 8'h02);
		rdchk("unmapped", 16'h0010, 8'h00);
		rate("rate main4", 8'h08);
		$display("test reset done");
		bus(1'b1, A_MS, 8'h01);
		bus(1'b1, A_MS, 8'h00);
		rdchk("mult kept", A_MS, 8'h01);
		bus(1'b1, A_PC, 8'h82);
		rdchk("stop on main", A_PC, 8'h02);
		bus(1'b1, A_OM, 8'h03);
		rdchk("osc mask", A_OM, 8'h03);
		chk("sub osc", 8'h00, 8'(sub_osc_en));
		chk("resistor", 8'h01, 8'(feedback_resistor_off));
		bus(1'b1, A_OM, 8'h00);
		bus(1'b1, A_CT, 8'h10);
		rdchk("status old", A_CT, 8'h10);
		// Longest switch is 306 ticks of the old main oscillator, counted ahead of its /4 divider.
		repeat (3000) @(posedge clk);
		rdchk("status sub", A_CT, 8'h30);
		rate("rate sub x4", 8'h10);
		$display("test switch done");
		bus(1'b1, A_PC, 8'h80);
		bus(1'b1, A_SB, 8'h02);
		@(negedge clk);
		chk("main osc", 8'h00, 8'(main_osc_en));
		chk("stop on sub", 8'h00, 8'(stop_active));
		bus(1'b1, A_SB, 8'h01);
		@(negedge clk);
		chk("halt", 8'h01, 8'(halt_active));
		rate("rate halt", 8'h00);
		wake_up();
		chk("halt off", 8'h00, 8'(halt_active));
		chk("mult wait", 8'h00, 8'(mult_en));
		repeat (40) @(negedge clk);
		chk("mult run", 8'h01, 8'(mult_en));
		rate("rate woken", 8'h10);
		$display("test standby done");
		rst();
		bus(1'b1, A_MS, 8'h01);
		rdchk("mult again", A_MS, 8'h01);
		bus(1'b1, A_SB, 8'h02);
		@(negedge clk);
		chk("stop", 8'h01, 8'(stop_active));
		chk("osc in stop", 8'h00, 8'(main_osc_en));
		wake_up();
		chk("stop off", 8'h00, 8'(stop_active));
		$display("test second reset done");
		close_out();
	end
endmodule // test_cpu_clock_source_select
bind ccs_top ccs_chk i_chk
(
	.clk(clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .main_tick(main_tick), .sub_tick(sub_tick),
	.mult_tick(mult_tick), .main_osc_en(main_osc_en),
	.sub_osc_en(sub_osc_en), .mult_en(mult_en),
	.periph_clk_en(periph_clk_en), .sub_periph_clk_en(sub_periph_clk_en),
	.adc_sub_clk_en(adc_sub_clk_en), .halt_active(halt_active),
	.stop_active(stop_active)
);
